// ### design/bpl_pkg.sv
// Package: constants and types for the backplane pulse line interface
package bpl_pkg;

  // ----------------------------------------
  // Register map (printed offsets 0x06, 0x07 are not multiples of four: index * 4)
  // ----------------------------------------
  localparam logic [7:0] CFG_IDX = 8'h06;
  localparam logic [7:0] SETUP_ONE_IDX = 8'h07;
  localparam logic [7:0] TXCTL_IDX = 8'h08;
  localparam logic [7:0] STAT_IDX = 8'h09;
  localparam logic [11:0] CFG_ADDR = {2'b00, CFG_IDX, 2'b00};
  localparam logic [11:0] SETUP_ONE_ADDR = {2'b00, SETUP_ONE_IDX, 2'b00};
  localparam logic [11:0] TXCTL_ADDR = {2'b00, TXCTL_IDX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {2'b00, STAT_IDX, 2'b00};

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CFG_BACKPLANE_BIT = 2;
  localparam int CFG_TX_ENABLE_POLARITY_PIN_BIT = 5;
  localparam int SETUP_ONE_PUSHPULL_BIT = 7;
  localparam int TXCTL_DIFF_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] SETUP_ONE_RST = 8'h00;
  localparam logic [7:0] TXCTL_RST = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int PULSE_NS = 200;
  localparam int BIT_RATE_KBPS = 2500;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int BIT_CYC = (CLK_MHZ * 1000) / BIT_RATE_KBPS;
  localparam int HALF_BIT_CYC = BIT_CYC / 2;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 1;

endpackage : bpl_pkg

// ### design/bpl_bit_fifo.sv
// Bit FIFO between the transmit bit stream and the pulse transmitter
`timescale 1ns/10ps
module bpl_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic do_wr;
  logic do_rd;

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];
  assign level = cnt_ff;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : bpl_bit_fifo

// ### design/bpl_rx_decode.sv
// Receive decoder: negative pulse per bit cell becomes a one
`timescale 1ns/10ps
module bpl_rx_decode
  import bpl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  input wire logic rx_pulse_in,
  // Decoded stream
  output logic rx_bit_valid,
  output logic rx_bit
);
  logic rx_d_ff;
  logic active_ff;
  logic seen_ff;
  logic [7:0] cnt_ff;
  logic fall;

  assign fall = rx_d_ff && !rx_pulse_in;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_d_ff <= 1'b1;
    end else begin
      rx_d_ff <= rx_pulse_in;
    end
  end

  // Cell timer restarts on a pulse unless the open cell count is 1 to HALF_BIT_CYC - 1; cells without a pulse yield zeros
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_ff <= 1'b0;
      seen_ff <= 1'b0;
      cnt_ff <= '0;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      rx_bit_valid <= 1'b0;
      if (!enable) begin
        active_ff <= 1'b0;
        seen_ff <= 1'b0;
      end else if (fall && (!active_ff || cnt_ff == 8'd0 || cnt_ff >= 8'(HALF_BIT_CYC))) begin
        // A pulse right at a cell wrap opens the new cell; the old one is already out
        if (active_ff && cnt_ff != 8'd0) begin
          rx_bit_valid <= 1'b1; // see [R03]
          rx_bit <= seen_ff;
        end
        active_ff <= 1'b1;
        seen_ff <= 1'b1;
        cnt_ff <= 8'd1;
      end else if (active_ff) begin
        if (cnt_ff == 8'(BIT_CYC - 1)) begin
          rx_bit_valid <= 1'b1; // see [R03]
          rx_bit <= seen_ff;
          seen_ff <= 1'b0;
          cnt_ff <= '0;
        end else begin
          cnt_ff <= cnt_ff + 8'd1;
        end
      end
    end
  end
endmodule : bpl_rx_decode

// ### design/bpl_line_if.sv
// Top: APB registers, bit FIFO, backplane pulse transmitter and receiver
//
// Contract
// [R01] Push-pull or open-drain driver; open-drain default
// [R02] One is 200 ns low pulse; zero none
// [R03] Received low pulse is one, none zero
// [R04] Backplane mode drives clock on second output; the code leaves it undriven when the strap reads low at reset
// [R05] Differential mode pulses only while enable active
// [R06] Reset holds all line outputs inactive
// [R07] Strap at reset picks enable polarity
// [R08] Strapped polarity applies only in backplane mode
// [R09] Backplane bit selects pulse signalling, else hybrid
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
module bpl_line_if
  import bpl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit bit stream in
  input wire logic tx_bit_valid,
  output logic tx_bit_ready,
  input wire logic tx_bit,
  // Received bit stream out
  output logic rx_bit_valid,
  output logic rx_bit,
  // Media pins
  output logic tx_pulse_out_o,
  output logic tx_pulse_out_oe,
  input wire logic aux_pulse_clock_in,
  output logic aux_pulse_clock_out_o,
  output logic aux_pulse_clock_out_oe,
  output logic tx_enable_out,
  input wire logic rx_pulse_in,
  // Hybrid mode indication
  output logic hybrid_mode
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] cfg_ff;
  logic [7:0] setup_one_ff;
  logic [7:0] txctl_ff;
  logic strap_high_ff;
  logic strap_done_ff;
  logic backplane;
  logic pushpull;
  logic diff_mode;
  logic tx_en_req;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction : hit

  logic wr_acc;
  logic mapped;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = hit(paddr, CFG_ADDR) || hit(paddr, SETUP_ONE_ADDR) ||
                  hit(paddr, TXCTL_ADDR) || hit(paddr, STAT_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign backplane = cfg_ff[CFG_BACKPLANE_BIT]; // see [R09]
  assign hybrid_mode = !backplane; // see [R09]
  assign pushpull = setup_one_ff[SETUP_ONE_PUSHPULL_BIT];
  assign diff_mode = txctl_ff[TXCTL_DIFF_BIT];
  assign tx_en_req = cfg_ff[CFG_TX_ENABLE_POLARITY_PIN_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= CFG_RST;
      setup_one_ff <= SETUP_ONE_RST; // see [R01]
      txctl_ff <= TXCTL_RST;
    end else if (wr_acc) begin
      if (hit(paddr, CFG_ADDR)) begin
        cfg_ff <= pwdata[7:0];
      end
      if (hit(paddr, SETUP_ONE_ADDR)) begin
        setup_one_ff <= pwdata[7:0];
      end
      if (hit(paddr, TXCTL_ADDR)) begin
        txctl_ff <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Polarity strap, caught once after reset release
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_ff <= 1'b0;
      strap_high_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      strap_high_ff <= !aux_pulse_clock_in; // see [R07]
    end
  end

  // ----------------------------------------
  // Transmit FIFO and pulse generator
  // ----------------------------------------
  logic f_valid;
  logic f_ready;
  logic [0:0] f_data;
  logic [5:0] f_level;
  logic [7:0] bit_cnt_ff;
  logic [7:0] pulse_cnt_ff;
  logic pulse_ff;
  logic tx_act_ff;
  logic bit_start;
  logic tx_allowed;
  logic [7:0] prd;

  bpl_bit_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(tx_bit_valid),
    .in_ready(tx_bit_ready),
    .in_data(tx_bit),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data),
    .level(f_level)
  );

  // Differential driver: no pulses unless enable is on
  assign tx_allowed = backplane && (!diff_mode || tx_en_req); // see [R05]
  assign bit_start = tx_allowed && (bit_cnt_ff == 8'd0) && strap_done_ff;
  assign f_ready = bit_start;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_ff <= '0;
      tx_act_ff <= 1'b0;
    end else if (bit_start && f_valid) begin
      bit_cnt_ff <= 8'(BIT_CYC - 1);
      tx_act_ff <= 1'b1;
    end else if (bit_cnt_ff != 8'd0) begin
      bit_cnt_ff <= bit_cnt_ff - 8'd1;
    end else begin
      tx_act_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_ff <= 1'b0; // see [R06]
      pulse_cnt_ff <= '0;
    end else if (bit_start && f_valid && f_data[0]) begin
      pulse_ff <= 1'b1; // see [R02]
      pulse_cnt_ff <= 8'(PULSE_CYC - 1);
    end else if (pulse_cnt_ff != 8'd0) begin
      pulse_cnt_ff <= pulse_cnt_ff - 8'd1;
    end else begin
      pulse_ff <= 1'b0;
    end
  end

  // Pulse line low while pulsing; open-drain releases for high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_pulse_out_o <= 1'b1;
      tx_pulse_out_oe <= 1'b0; // see [R06]
    end else begin
      tx_pulse_out_o <= !pulse_ff;
      tx_pulse_out_oe <= backplane && (pulse_ff || pushpull); // see [R01]
    end
  end

  // Bit-cell clock on second output, low in first half of each cell
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_pulse_clock_out_o <= 1'b1;
      aux_pulse_clock_out_oe <= 1'b0; // see [R06]
    end else begin
      aux_pulse_clock_out_o <= !(tx_act_ff && bit_cnt_ff >= 8'(HALF_BIT_CYC)); // see [R04]
      aux_pulse_clock_out_oe <= backplane && !strap_high_ff; // see [R04]
    end
  end

  // Enable output: strapped polarity only in backplane mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_enable_out <= 1'b1; // see [R06]
    end else begin
      if (backplane && strap_high_ff) begin
        tx_enable_out <= tx_en_req && diff_mode; // see [R08]
      end else begin
        tx_enable_out <= !(tx_en_req && diff_mode && backplane); // see [R08]
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  bpl_rx_decode u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .enable(backplane),
    .rx_pulse_in(rx_pulse_in),
    .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    prd = 8'h00;
    if (hit(paddr, CFG_ADDR)) begin
      prd = cfg_ff;
    end else if (hit(paddr, SETUP_ONE_ADDR)) begin
      prd = setup_one_ff;
    end else if (hit(paddr, TXCTL_ADDR)) begin
      prd = txctl_ff;
    end else if (hit(paddr, STAT_ADDR)) begin
      prd = {f_level[5:0], strap_high_ff, tx_act_ff};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, prd};
    end
  end
endmodule : bpl_line_if

// ### test/bpl_wire_model.sv
// Partner: backplane wire and strap pin
`timescale 1ns/10ps
module bpl_wire_model (
  // Device pins
  input wire logic tx_o,
  input wire logic tx_oe,
  input wire logic aux_o,
  input wire logic aux_oe,
  input wire logic strap_gnd,
  // Resolved levels
  output logic line,
  output logic aux_pin
);
  // Media pull-up: a released wire reads high
  assign line = tx_oe ? tx_o : 1'b1;
  // Grounded strap stays grounded
  assign aux_pin = strap_gnd ? 1'b0 : (aux_oe ? aux_o : 1'b1);
endmodule : bpl_wire_model

// ### test/bpl_line_if_assertions.sv
// Checker for the line pins
`timescale 1ns/10ps
module bpl_line_if_assertions
  import bpl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Line
  input wire logic tx_pulse_out_o,
  input wire logic tx_pulse_out_oe,
  input wire logic aux_pulse_clock_out_o,
  input wire logic aux_pulse_clock_out_oe,
  input wire logic tx_enable_out,
  input wire logic rx_bit_valid,
  input wire logic hybrid_mode
);
  logic [7:0] low_ff;
  logic [7:0] gap_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) low_ff <= 8'h00;
    else low_ff <= tx_pulse_out_o ? 8'h00 : low_ff + 8'h01;
  // Saturates so the first pulse after reset passes
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) gap_ff <= 8'hff;
    else if ($fell(tx_pulse_out_o)) gap_ff <= 8'h01;
    else if (gap_ff != 8'hff) gap_ff <= gap_ff + 8'h01;
  rst_idle_a: assert property (disable iff (1'b0) !rst_b ##1 !rst_b |-> tx_pulse_out_o &&
    !tx_pulse_out_oe && !aux_pulse_clock_out_oe && tx_enable_out) else $error("Active in reset");
  pulse_len_a: assert property ($rose(tx_pulse_out_o) |-> low_ff == PULSE_CYC)
    else $error("Pulse width");
  pulse_gap_a: assert property ($fell(tx_pulse_out_o) |-> gap_ff >= BIT_CYC)
    else $error("Pulse gap");
  drive_low_a: assert property (!tx_pulse_out_o |-> tx_pulse_out_oe)
    else $error("Pulse undriven");
  no_hybrid_a: assert property ($fell(tx_pulse_out_o) |-> !hybrid_mode)
    else $error("Pulse in hybrid");
  aux_low_a: assert property (aux_pulse_clock_out_oe && $fell(aux_pulse_clock_out_o) |->
    !aux_pulse_clock_out_o [*8]) else $error("Clock low short");
  rx_one_a: assert property (rx_bit_valid |=> !rx_bit_valid [*8])
    else $error("Strobe too long");
  err_acc_a: assert property (pslverr |-> psel && penable && pready)
    else $error("Error outside access");
endmodule : bpl_line_if_assertions

// ### test/tb_top.sv
// Testbench: registers, looped-back frames, enable polarity
`timescale 1ns/10ps
module tb_top;
  import bpl_pkg::*;
  localparam logic [31:0] BP = 32'h0000_0001 << CFG_BACKPLANE_BIT;
  localparam logic [31:0] TE = 32'h0000_0001 << CFG_TX_ENABLE_POLARITY_PIN_BIT;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, tx_bit_valid = 0, tx_bit = 0, strap_gnd = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_bit_ready, rx_bit_valid, rx_bit, tx_pulse_out_o, tx_pulse_out_oe, rx_pulse_in;
  logic aux_pulse_clock_in, aux_pulse_clock_out_o, aux_pulse_clock_out_oe, tx_enable_out, hybrid_mode;
  logic po = 1, pa = 1, b;
  int errors = 0, checks_done = 0, seed = 64742, n, nf = 0, na = 0;
  logic [32:0] rq[$];
  logic bq[$];
  always #2 clk = ~clk;
  bpl_line_if u_bpl_line_if (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_bit_valid, .tx_bit_ready, .tx_bit, .rx_bit_valid, .rx_bit, .tx_pulse_out_o, .tx_pulse_out_oe,
    .aux_pulse_clock_in, .aux_pulse_clock_out_o, .aux_pulse_clock_out_oe, .tx_enable_out, .rx_pulse_in,
    .hybrid_mode);
  bpl_wire_model u_bpl_wire_model (.tx_o(tx_pulse_out_o), .tx_oe(tx_pulse_out_oe), .aux_o(aux_pulse_clock_out_o),
    .aux_oe(aux_pulse_clock_out_oe), .strap_gnd, .line(rx_pulse_in), .aux_pin(aux_pulse_clock_in));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, '0);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic test_done();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Results are compared as they appear
  always @(posedge clk) begin
    po <= tx_pulse_out_o;
    pa <= aux_pulse_clock_out_o;
    if (po && !tx_pulse_out_o) nf++;
    if (pa && !aux_pulse_clock_out_o) na++;
    if (psel && penable && pready && !pwrite && rq.size() > 0) chk({pslverr, prdata}, rq.pop_front());
    if (rx_bit_valid && bq.size() > 0) chk({32'h0, rx_bit}, {32'h0, bq.pop_front()});
  end
  initial begin
    repeat (12) @(posedge clk);
    chk(33'({tx_pulse_out_oe, aux_pulse_clock_out_oe, tx_enable_out}), 33'h1);
    rst_b <= 1;
    @(posedge clk);
    rd(CFG_ADDR, 33'(CFG_RST));
    rd(SETUP_ONE_ADDR, 33'(SETUP_ONE_RST));
    rd(TXCTL_ADDR, 33'(TXCTL_RST));
    rd(12'h000, 33'h1_0000_0000);
    chk(33'(hybrid_mode), 33'h1);
    $display("Test registers done");
    // First bit is a one so the receiver locks onto the cell grid
    n = 0;
    do begin
      b = (n == 0) ? 1'b1 : 1'($random(seed));
      tx_bit <= b;
      tx_bit_valid <= 1'b1;
      bq.push_back(b);
      @(posedge clk);
      n++;
    end while (n < FIFO_DEPTH);
    tx_bit_valid <= 1'b0;
    @(posedge clk);
    chk(33'(n), 33'(FIFO_DEPTH));
    chk(33'(tx_bit_ready), '0);
    rd(STAT_ADDR, 33'h80);
    na = 0;
    wr(CFG_ADDR, BP);
    chk(33'(hybrid_mode), '0);
    repeat (4000) if (bq.size() > 0) @(posedge clk);
    chk(33'({bq.size() == 0, na > 0, tx_pulse_out_oe}), 33'h6);
    wr(SETUP_ONE_ADDR, 32'h0000_0001 << SETUP_ONE_PUSHPULL_BIT);
    chk(33'({tx_pulse_out_o, tx_pulse_out_oe}), 33'h3);
    $display("Test frame done");
    wr(TXCTL_ADDR, 32'h0000_0001 << TXCTL_DIFF_BIT);
    tx_bit <= 1'b1;
    tx_bit_valid <= 1'b1;
    @(posedge clk);
    tx_bit_valid <= 1'b0;
    n = nf;
    repeat (300) @(posedge clk);
    chk(33'({nf == n, tx_enable_out}), 33'h3);
    wr(CFG_ADDR, BP | TE);
    repeat (300) @(posedge clk);
    chk(33'({nf == n + 1, tx_enable_out}), 33'h2);
    $display("Test differential done");
    strap_gnd <= 1'b1;
    rst_b <= 0;
    repeat (12) @(posedge clk);
    chk(33'({tx_pulse_out_oe, aux_pulse_clock_out_oe, tx_enable_out}), 33'h1);
    rst_b <= 1;
    @(posedge clk);
    wr(TXCTL_ADDR, 32'h0000_0001);
    wr(CFG_ADDR, TE);
    chk(33'(tx_enable_out), 33'h1);
    wr(CFG_ADDR, BP | TE);
    chk(33'(tx_enable_out), 33'h1);
    wr(CFG_ADDR, BP);
    chk(33'({tx_enable_out, aux_pulse_clock_out_oe}), '0);
    $display("Test polarity done");
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule : tb_top
bind bpl_line_if bpl_line_if_assertions u_bpl_line_if_assertions (.clk, .rst_b, .psel, .penable, .pready,
  .pslverr, .tx_pulse_out_o, .tx_pulse_out_oe, .aux_pulse_clock_out_o, .aux_pulse_clock_out_oe,
  .tx_enable_out, .rx_bit_valid, .hybrid_mode);
